// *** rtl/idc_pkg.sv ***
// Shared constants, field layouts and types of the instruction decoder.
// Assumes a single 50 MHz clock and a same-clock memory port.
package idc_pkg;
  localparam int unsigned W = 30;
  localparam int unsigned AW = 15;
  localparam int unsigned CW = 6;
  localparam int unsigned RAW = 8;

  // Instruction word layout, most significant field first
  typedef struct packed {
    logic [5:0] f;
    logic [3:0] j;
    logic [1:0] k;
    logic [2:0] b;
    logic [14:0] y;
  } idc_instr_t;

  // Memory request towards main memory
  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [29:0] wdata;
  } idc_mem_t;

  // Control memory window 00100..00177 octal: upper address bits
  localparam logic [8:0] CTRL_PAGE = 9'h001;
  localparam int unsigned CTRL_DEPTH = 64;

  // Function codes; 01..076 octal form the repertory
  localparam logic [5:0] F_LO = 6'h01;
  localparam logic [5:0] F_HI = 6'h3e;
  localparam logic [5:0] F_LDA = 6'h10;
  localparam logic [5:0] F_LDQ = 6'h11;
  localparam logic [5:0] F_ADD = 6'h20;
  localparam logic [5:0] F_SUB = 6'h21;
  localparam logic [5:0] F_JMP = 6'h22;
  localparam logic [5:0] F_RJP = 6'h23;
  localparam logic [5:0] F_STA = 6'h30;
  localparam logic [5:0] F_STQ = 6'h31;

  // Operand interpretation
  localparam logic [1:0] K_FULL = 2'h0;
  localparam logic [1:0] K_LOW = 2'h1;
  localparam logic [1:0] K_LOWSX = 2'h2;
  localparam logic [1:0] K_UP = 2'h3;

  // Branch conditions; codes above 7 carry a channel or minor function
  localparam logic [3:0] J_NONE = 4'h0;
  localparam logic [3:0] J_ALWAYS = 4'h1;
  localparam logic [3:0] J_QPOS = 4'h2;
  localparam logic [3:0] J_QNEG = 4'h3;
  localparam logic [3:0] J_AZERO = 4'h4;
  localparam logic [3:0] J_ANZ = 4'h5;
  localparam logic [3:0] J_APOS = 4'h6;
  localparam logic [3:0] J_ANEG = 4'h7;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_ACC = 8'h14;
  localparam logic [7:0] REG_AUX = 8'h18;
  localparam logic [7:0] REG_INSTR = 8'h1c;

  // Status and mask bits
  localparam int unsigned NEV = 3;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_CHAN = 1;
  localparam int unsigned EV_SKIP = 2;
  localparam int unsigned CTRL_RUN = 0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_FWAIT = 4'h2,
    ST_DECODE = 4'h3,
    ST_OWAIT = 4'h4,
    ST_EXEC = 4'h5,
    ST_SWAIT = 4'h6,
    ST_FIN = 4'h7,
    ST_EXTI = 4'h8,
    ST_FAULT = 4'h9
  } idc_state_t;
endpackage

// *** rtl/idc_oc_sub.sv ***
// Ones' complement subtractor with end-around borrow.
// Combinational; an addition is done by subtracting the complement.
`timescale 1ns/1ps
module idc_oc_sub #(
  parameter int unsigned WD = 30
) (
  input wire logic [WD-1:0] a,
  input wire logic [WD-1:0] b,
  output logic [WD-1:0] res
);
  logic [WD:0] diff;

  always_comb begin
    diff = {1'b0, a} - {1'b0, b};
    if (diff[WD]) begin
      res = diff[WD-1:0] - {{(WD-1){1'b0}}, 1'b1};
    end else begin
      res = diff[WD-1:0];
    end
  end
endmodule

// *** rtl/idc_operand_fmt.sv ***
// Operand interpretation: full word or half-word with optional sign.
// Combinational; fed from the operand register of the sequencer.
`timescale 1ns/1ps
module idc_operand_fmt import idc_pkg::*; (
  input wire logic [W-1:0] word,
  input wire logic [1:0] mode,
  output logic [W-1:0] opnd
);
  always_comb begin
    case (mode)
      K_LOW: opnd = {{(W-AW){1'b0}}, word[AW-1:0]};
      K_LOWSX: opnd = {{(W-AW){word[AW-1]}}, word[AW-1:0]};
      K_UP: opnd = {{(W-AW){1'b0}}, word[W-1:AW]};
      default: opnd = word;
    endcase
  end
endmodule

// *** rtl/idc_decoder.sv ***
// Instruction fetch, decode and operand sequencer with control memory.
// Assumes main memory on the same clock answering with mem_ack.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Split word into code, designator, modifiers
// - Codes 01..076 valid, seven index registers
// - Modifiers pick index, interpretation, branch, function
// - Add selected index register to designator
// - Operand full word or half-word, sign optional
// - Skip next instruction when condition holds
// - Fetch sequentially except skip, jump, subroutine
// - Ones' complement subtractive arithmetic into accumulator
// - No fetch from control memory, operands allowed
// - Sixty-four control words, index registers among them
// - Program may store over its own instructions
// - External request sets up channel, then resumes
// - Instruction held in register through execution
// - Index add is 15-bit ones' complement
// - Fetch from control memory enters fault
// - Addresses 00100..00177 octal are control memory
module idc_decoder import idc_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output idc_mem_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [W-1:0] mem_rdata,
  input wire logic ext_req,
  input wire logic [3:0] ext_chan,
  output logic chan_setup,
  output logic [3:0] chan_num
);
  idc_state_t state, next_state;
  idc_instr_t ir, next_ir;
  idc_mem_t next_mem_cmd;
  logic [AW-1:0] p, next_p;
  logic [W-1:0] acc, next_acc, aux, next_aux, opnd, next_opnd;
  logic [W-1:0] cmem [CTRL_DEPTH];
  logic [W-1:0] next_cmem [CTRL_DEPTH];
  logic [NEV-1:0] status, next_status, mask, next_mask, ev;
  logic run, next_run, ext_pend, next_ext_pend;
  logic next_chan_setup;
  logic [3:0] next_chan_num;
  logic [31:0] next_rdata;
  logic [1:0] req_sync;
  logic [3:0] chan_q0, chan_q1;
  logic req_prev;
  logic [AW-1:0] ea, idx_sum, p_one, p_two;
  logic ea_ctrl, p_ctrl, f_valid, skip, jump;
  logic [W-1:0] fmt, alu_b, alu_res, st_data;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_sync <= 2'h0;
      chan_q0 <= 4'h0;
      chan_q1 <= 4'h0;
      req_prev <= 1'b0;
    end else begin
      req_sync <= {req_sync[0], ext_req};
      chan_q0 <= ext_chan;
      chan_q1 <= chan_q0;
      req_prev <= req_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address modification and operand path
  idc_oc_sub #(.WD(AW)) u_idx (
    .a(ir.y),
    .b(~cmem[ir.b][AW-1:0]),
    .res(idx_sum)
  );
  assign ea = (ir.b != 3'h0) ? idx_sum : ir.y;
  assign ea_ctrl = (ea[AW-1:CW] == CTRL_PAGE);
  assign p_ctrl = (p[AW-1:CW] == CTRL_PAGE);
  assign f_valid = (ir.f >= F_LO) && (ir.f <= F_HI);
  assign p_one = p + {{(AW-1){1'b0}}, 1'b1};
  assign p_two = p_one + {{(AW-1){1'b0}}, 1'b1};

  idc_operand_fmt u_fmt (
    .word(opnd),
    .mode(ir.k),
    .opnd(fmt)
  );

  assign alu_b = (ir.f == F_SUB) ? fmt : ~fmt;
  idc_oc_sub #(.WD(W)) u_alu (
    .a(acc),
    .b(alu_b),
    .res(alu_res)
  );

  always_comb begin
    case (ir.f)
      F_STQ: st_data = aux;
      F_RJP: st_data = {{(W-AW){1'b0}}, p_one};
      default: st_data = acc;
    endcase
  end

  // Branch condition on accumulator or auxiliary register
  always_comb begin
    case (ir.j)
      J_ALWAYS: skip = 1'b1;
      J_QPOS: skip = !aux[W-1];
      J_QNEG: skip = aux[W-1];
      J_AZERO: skip = (acc == '0) || (acc == '1);
      J_ANZ: skip = (acc != '0) && (acc != '1);
      J_APOS: skip = !acc[W-1];
      J_ANEG: skip = acc[W-1];
      default: skip = 1'b0;
    endcase
  end
  assign jump = (ir.f == F_JMP) || (ir.f == F_RJP);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_ir = ir;
    next_p = p;
    next_acc = acc;
    next_aux = aux;
    next_opnd = opnd;
    next_cmem = cmem;
    next_mem_cmd = '0;
    next_chan_setup = 1'b0;
    next_chan_num = chan_num;
    next_ext_pend = ext_pend;
    next_run = run;
    next_mask = mask;
    ev = '0;
    case (state)
      ST_IDLE: begin
        if (run) next_state = ST_FETCH;
      end
      ST_FETCH: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (ext_pend) begin
          next_state = ST_EXTI;
        end else if (p_ctrl) begin
          next_state = ST_FAULT;
          ev[EV_FAULT] = 1'b1;
        end else begin
          next_mem_cmd.req = 1'b1;
          next_mem_cmd.addr = p;
          next_state = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        if (mem_ack) begin
          next_ir = mem_rdata;
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (!f_valid) begin
          next_state = ST_FAULT;
          ev[EV_FAULT] = 1'b1;
        end else if (ir.f == F_LDA || ir.f == F_LDQ ||
                     ir.f == F_ADD || ir.f == F_SUB) begin
          if (ea_ctrl) begin
            next_opnd = cmem[ea[CW-1:0]];
            next_state = ST_EXEC;
          end else begin
            next_mem_cmd.req = 1'b1;
            next_mem_cmd.addr = ea;
            next_state = ST_OWAIT;
          end
        end else if (ir.f == F_STA || ir.f == F_STQ || ir.f == F_RJP) begin
          if (ea_ctrl) begin
            next_cmem[ea[CW-1:0]] = st_data;
            next_state = ST_FIN;
          end else begin
            next_mem_cmd.req = 1'b1;
            next_mem_cmd.we = 1'b1;
            next_mem_cmd.addr = ea;
            next_mem_cmd.wdata = st_data;
            next_state = ST_SWAIT;
          end
        end else begin
          next_state = ST_FIN;
        end
      end
      ST_OWAIT: begin
        if (mem_ack) begin
          next_opnd = mem_rdata;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (ir.f)
          F_LDA: next_acc = fmt;
          F_LDQ: next_aux = fmt;
          default: next_acc = alu_res;
        endcase
        next_state = ST_FIN;
      end
      ST_SWAIT: begin
        if (mem_ack) next_state = ST_FIN;
      end
      ST_FIN: begin
        if (ir.f == F_JMP) begin
          next_p = ea;
        end else if (ir.f == F_RJP) begin
          next_p = ea + {{(AW-1){1'b0}}, 1'b1};
        end else if (skip) begin
          next_p = p_two;
          ev[EV_SKIP] = 1'b1;
        end else begin
          next_p = p_one;
        end
        next_state = ST_FETCH;
      end
      ST_EXTI: begin
        next_chan_setup = 1'b1;
        next_chan_num = chan_q1;
        next_ext_pend = 1'b0;
        ev[EV_CHAN] = 1'b1;
        next_state = ST_FETCH;
      end
      default: begin
        next_state = ST_FAULT;
      end
    endcase
    if (req_sync[1] && !req_prev) next_ext_pend = 1'b1;
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        next_run = reg_wdata[CTRL_RUN];
      end else if (reg_addr == REG_START) begin
        next_p = reg_wdata[AW-1:0];
        next_state = ST_IDLE;
      end else if (reg_addr == REG_MASK) begin
        next_mask = reg_wdata[NEV-1:0];
      end
    end
    next_status = status | ev;
    if (reg_wr && reg_addr == REG_STATUS) begin
      next_status = (status & ~reg_wdata[NEV-1:0]) | ev;
    end
  end

  // Register read port
  always_comb begin
    next_rdata = 32'h0;
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        next_rdata = {31'h0, run};
      end else if (reg_addr == REG_STATUS) begin
        next_rdata = {{(32-NEV){1'b0}}, status};
      end else if (reg_addr == REG_MASK) begin
        next_rdata = {{(32-NEV){1'b0}}, mask};
      end else if (reg_addr == REG_PC) begin
        next_rdata = {{(32-AW){1'b0}}, p};
      end else if (reg_addr == REG_ACC) begin
        next_rdata = {2'h0, acc};
      end else if (reg_addr == REG_AUX) begin
        next_rdata = {2'h0, aux};
      end else if (reg_addr == REG_INSTR) begin
        next_rdata = {2'h0, ir};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      ir <= '0;
      p <= '0;
      acc <= '0;
      aux <= '0;
      opnd <= '0;
      mem_cmd <= '0;
      chan_setup <= 1'b0;
      chan_num <= 4'h0;
      ext_pend <= 1'b0;
      run <= 1'b0;
      mask <= '0;
      status <= '0;
      reg_rdata <= 32'h0;
      for (int i = 0; i < CTRL_DEPTH; i++) cmem[i] <= '0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      p <= next_p;
      acc <= next_acc;
      aux <= next_aux;
      opnd <= next_opnd;
      mem_cmd <= next_mem_cmd;
      chan_setup <= next_chan_setup;
      chan_num <= next_chan_num;
      ext_pend <= next_ext_pend;
      run <= next_run;
      mask <= next_mask;
      status <= next_status;
      reg_rdata <= next_rdata;
      for (int i = 0; i < CTRL_DEPTH; i++) cmem[i] <= next_cmem[i];
    end
  end

  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_ctrl_fetch_fault: assert property (
    state == ST_FETCH && run && !ext_pend && p_ctrl && !reg_wr
    |=> state == ST_FAULT && status[EV_FAULT])
    else $error("fetch from control memory did not fault");
  a_fetch_main_only: assert property (
    mem_cmd.req && state == ST_FWAIT
    |-> mem_cmd.addr[AW-1:CW] != CTRL_PAGE)
    else $error("instruction fetched from control memory");
  a_seq_next_addr: assert property (
    state == ST_FIN && !jump && !skip && !reg_wr |=> p == $past(p) + 15'h1)
    else $error("sequential address not advanced by one");
  a_skip_two: assert property (
    state == ST_FIN && !jump && skip && !reg_wr
    |=> p == $past(p) + 15'h2 ##0 status[EV_SKIP])
    else $error("skip did not pass over next instruction");
  a_index_none: assert property (
    state == ST_DECODE && ir.b == 3'h0 && f_valid && ea_ctrl
    && (ir.f == F_LDA) |=> opnd == $past(cmem[ir.y[CW-1:0]]))
    else $error("unmodified designator read wrong control word");
  a_bad_code_fault: assert property (
    state == ST_DECODE && !f_valid && !reg_wr |=> state == ST_FAULT)
    else $error("invalid function code executed");
  a_ir_hold: assert property (
    !$stable(ir) |-> $past(state) == ST_FWAIT)
    else $error("instruction register changed during execution");
  a_ext_setup: assert property (
    state == ST_EXTI && !reg_wr
    |=> chan_setup && status[EV_CHAN] && state == ST_FETCH ##1 !chan_setup)
    else $error("channel setup not a single pulse");
  a_sub_result: assert property (
    state == ST_EXEC && ir.f == F_SUB && fmt == acc |=> acc == '0)
    else $error("subtracting equal values did not give plus zero");
  a_low_signext: assert property (
    ir.k == K_LOWSX |-> fmt[W-1:AW] == {(W-AW){opnd[AW-1]}})
    else $error("half-word sign extension wrong");

  c_fault: cover property (state == ST_FETCH ##1 state == ST_FAULT);
  c_skip: cover property (state == ST_FIN && skip && !jump);
  c_ext: cover property (chan_setup);
  c_ctrl_opnd: cover property (state == ST_DECODE && ea_ctrl && ir.b != 3'h0);
endmodule

// *** test/idc_mem_model.sv ***
// Behavioural main memory answering the decoder's memory port.
// Assumes one request at a time on the shared clock.
`timescale 1ns/1ps
module idc_mem_model import idc_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire idc_mem_t mem_cmd,
  output logic mem_ack,
  output logic [W-1:0] mem_rdata
);
  logic [W-1:0] mem [0:32767];
  logic [14:0] addr;
  logic busy;
  logic slow;
  logic [1:0] cnt;
  ////////////////////////////////////////
  // Alternates prompt and slow answers; idle data toggles every cycle
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      busy <= 1'b0;
      slow <= 1'b0;
      mem_rdata <= '0;
    end else if (mem_cmd.req) begin
      busy <= 1'b1;
      addr <= mem_cmd.addr;
      cnt <= slow ? 2'h3 : 2'h0;
      slow <= ~slow;
      if (mem_cmd.we) begin
        mem[mem_cmd.addr] <= mem_cmd.wdata;
      end
    end else if (busy) begin
      if (cnt == 2'h0) begin
        busy <= 1'b0;
        mem_ack <= 1'b1;
        mem_rdata <= mem[addr];
      end else begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule

// *** test/test_idc_decoder.sv ***
// Self-checking bench for the instruction decoder and its memory.
// Assumes the memory model answers every request on the same clock.
`timescale 1ns/1ps
module test_idc_decoder import idc_pkg::*; ;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [RAW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  idc_mem_t mem_cmd;
  logic mem_ack;
  logic [W-1:0] mem_rdata;
  logic ext_req = 1'b0;
  logic [3:0] ext_chan = '0;
  logic chan_setup;
  logic [3:0] chan_num;
  logic rd_q = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'h18cd;
  logic [31:0] q_reg [$];
  logic [3:0] q_chan [$];
  logic [44:0] q_wr [$];
  logic [W-1:0] prog [$];
  logic [W-1:0] d0, d1, w2, d3, iw;
  logic [3:0] ch;

  idc_decoder uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ext_req(ext_req),
    .ext_chan(ext_chan), .chan_setup(chan_setup), .chan_num(chan_num));
  idc_mem_model u_mem (.clock(clock), .sys_rst(sys_rst),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #10 clock = ~clock;
  always @(posedge clock) rd_q <= reg_rd;

  ////////////////////////////////////////
  function automatic logic [W-1:0] ins(input logic [5:0] f,
      input logic [14:0] y, input logic [1:0] k = 2'h0,
      input logic [2:0] b = 3'h0, input logic [3:0] j = 4'h0);
    return {f, j, k, b, y};
  endfunction
  // Ones' complement sum: subtract the complement, borrow end-around
  function automatic logic [W-1:0] oc_add(input logic [W-1:0] a,
      input logic [W-1:0] b);
    return (a >= ~b) ? a - ~b : a - ~b - 30'h1;
  endfunction
  task automatic note(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got);
    note(q_reg.size() > 0 && got === q_reg[0], $sformatf("read %h", got));
    if (q_reg.size() > 0) void'(q_reg.pop_front());
  endtask
  task automatic chk_chan(input logic [3:0] got);
    note(q_chan.size() > 0 && got === q_chan[0], $sformatf("chan %h", got));
    if (q_chan.size() > 0) void'(q_chan.pop_front());
  endtask
  task automatic chk_wr(input logic [44:0] got);
    note(q_wr.size() > 0 && got === q_wr[0], $sformatf("store %h", got));
    if (q_wr.size() > 0) void'(q_wr.pop_front());
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    q_reg.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Output watcher: one result per strobe, pulse or store
  always @(negedge clock) begin
    if (rd_q) chk_reg(reg_rdata);
    if (chan_setup === 1'b1) chk_chan(chan_num);
    if (mem_cmd.req === 1'b1 && mem_cmd.we === 1'b1) begin
      chk_wr({mem_cmd.addr, mem_cmd.wdata});
    end
    if (mem_cmd.req === 1'b1) begin
      note(mem_cmd.addr[14:6] !== CTRL_PAGE, "control page on port");
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    d0 = 30'($random(seed));
    d1 = 30'($random(seed));
    w2 = 30'($random(seed)) | 30'h4000;
    d3 = 30'($random(seed));
    ch = 4'($random(seed));
    iw = ins(F_STA, 15'h316);
    prog = '{ins(F_LDA, 15'h300), ins(F_ADD, 15'h301), ins(F_STA, 15'h310),
      ins(F_LDA, 15'h302, K_LOW), ins(F_STA, 15'h311),
      ins(F_LDA, 15'h302, K_LOWSX), ins(F_STA, 15'h312),
      ins(F_LDA, 15'h303), ins(F_STA, 15'h041),
      ins(F_LDA, 15'h7ff0, K_FULL, 3'h1), ins(F_STA, 15'h313),
      ins(F_LO, 15'h0, K_FULL, 3'h0, J_ALWAYS), ins(F_STA, 15'h314),
      ins(F_STA, 15'h315), ins(F_LDA, 15'h304), ins(F_STA, 15'h210),
      ins(F_LO, 15'h0), ins(F_LDA, 15'h300), ins(F_SUB, 15'h300),
      ins(F_LO, 15'h0, K_FULL, 3'h0, J_AZERO), ins(F_STA, 15'h314),
      ins(F_LDQ, 15'h302, K_UP),
      ins(F_STQ, 15'h317, K_FULL, 3'h0, J_QPOS), ins(F_STA, 15'h314),
      ins(F_RJP, 15'h320)};
    foreach (prog[i]) u_mem.mem[15'h200 + i] = prog[i];
    u_mem.mem[15'h0] = '0;
    u_mem.mem[15'h300] = d0;
    u_mem.mem[15'h301] = d1;
    u_mem.mem[15'h302] = w2;
    u_mem.mem[15'h303] = 30'h20;
    u_mem.mem[15'h304] = iw;
    u_mem.mem[15'h011] = d3;
    // Subroutine entry lands here: control word read, then jump to fault
    u_mem.mem[15'h321] = ins(F_LDA, 15'h041);
    u_mem.mem[15'h322] = ins(F_STA, 15'h318);
    u_mem.mem[15'h323] = ins(F_LDA, 15'h304);
    u_mem.mem[15'h324] = ins(F_JMP, 15'h040);
    u_mem.mem[15'h330] = ins(6'h3f, 15'h0);
    q_wr.push_back({15'h310, oc_add(d0, d1)});
    q_wr.push_back({15'h311, 15'h0, w2[14:0]});
    q_wr.push_back({15'h312, {15{w2[14]}}, w2[14:0]});
    // Index 0x20 on 0x7ff0 wraps end-around to 0x0011
    q_wr.push_back({15'h313, d3});
    q_wr.push_back({15'h315, d3});
    q_wr.push_back({15'h210, iw});
    q_wr.push_back({15'h316, iw});
    q_wr.push_back({15'h317, 15'h0, w2[29:15]});
    q_wr.push_back({15'h320, 30'h219});
    q_wr.push_back({15'h318, 30'h20});
    q_chan.push_back(ch);
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_MASK, 32'h0);
    rd(REG_PC, 32'h0);
    rd(REG_ACC, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset_values done");
    wr(REG_START, 32'h200);
    rd(REG_PC, 32'h200);
    wr(REG_MASK, 32'h1);
    ext_chan <= ch;
    wr(REG_CTRL, 32'h1);
    ext_req <= 1'b1;
    repeat (6) @(posedge clock);
    ext_req <= 1'b0;
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clock);
    note(irq === 1'b1, "no fault raised");
    rd(REG_STATUS, 32'h7);
    rd(REG_ACC, {2'h0, iw});
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, 32'h6);
    note(irq === 1'b0, "interrupt stuck");
    rd(REG_PC, 32'h40);
    rd(REG_AUX, {17'h0, w2[29:15]});
    rd(REG_INSTR, {2'h0, ins(F_JMP, 15'h040)});
    wr(REG_START, 32'h330);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clock);
    note(irq === 1'b1, "invalid code did not fault");
    rd(REG_STATUS, 32'h7);
    repeat (3) @(posedge clock);
    note(q_wr.size() == 0, "stores missing");
    note(q_chan.size() == 0, "channel setup missing");
    note(q_reg.size() == 0, "read data missing");
    $display("test program_run done");
    report_and_stop();
  end
endmodule
